// ===== verilog/scp_pkg.sv
// Package: register map, mode codes and timing counts of the serial port
`default_nettype none
package scp_pkg;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] SCP_ADDR_CLK_DIV = 8'hA2; // Clock-rate divider
	localparam logic [7:0] SCP_ADDR_DATA    = 8'hA3; // Data buffer
	localparam logic [7:0] SCP_CLK_DIV_RST  = 8'h00; // Divider reset value
	localparam logic [7:0] SCP_DATA_RST     = 8'h00; // Data reset value
	localparam logic [7:0] SCP_UNMAPPED     = 8'h00; // Read of other offsets

	// ------------------------------------------------------------------
	// Slave-select mode codes
	// ------------------------------------------------------------------
	localparam logic [1:0] SCP_SSM_3WIRE = 2'h0; // Select pin unused
	localparam logic [1:0] SCP_SSM_4WIRE = 2'h1; // Select is an input
	localparam int         SCP_SSM_DRIVE = 1;    // Bit that marks driven mode

	// ------------------------------------------------------------------
	// Transfer shape
	// ------------------------------------------------------------------
	localparam int         SCP_BITS       = 8;    // Bits per transfer
	localparam logic [3:0] SCP_LAST_EDGE  = 4'hF; // Sixteenth clock edge
	localparam logic [2:0] SCP_LAST_BIT   = 3'h7; // Eighth sample
	localparam int         SCP_FIFO_DEPTH = 32;   // Transmit buffer words

	// ------------------------------------------------------------------
	// Timing, system clock 125 MHz
	// ------------------------------------------------------------------
	localparam int SCP_CLK_PS     = 8000; // System clock period
	localparam int SCP_SEZ_MAX_NS = 32;   // Select fall to output valid
	localparam int SCP_SDZ_MAX_NS = 32;   // Select rise to output release
	localparam int SCP_SLH_MIN_NS = 48;   // Last edge to output change
	localparam int SCP_SLH_MAX_NS = 64;   // Same, upper bound
	localparam int SCP_SEZ_CYC    = (SCP_SEZ_MAX_NS * 1000) / SCP_CLK_PS;
	localparam int SCP_SDZ_CYC    = (SCP_SDZ_MAX_NS * 1000) / SCP_CLK_PS;
	localparam int SCP_SLH_MIN_CYC =
		(SCP_SLH_MIN_NS * 1000 + SCP_CLK_PS - 1) / SCP_CLK_PS;
	localparam int SCP_SLH_MAX_CYC = (SCP_SLH_MAX_NS * 1000) / SCP_CLK_PS;
	localparam int SCP_SYNC_LAT   = 2;    // Synchroniser plus edge register
	localparam logic [2:0] SCP_HOLD_CYC =
		3'(SCP_SLH_MIN_CYC - SCP_SYNC_LAT);

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SCP_IDLE   = 2'b00,
		SCP_MASTER = 2'b01,
		SCP_SLAVE  = 2'b10,
		SCP_HOLD   = 2'b11
	} scp_state_t;
endpackage
`default_nettype wire

// ===== verilog/scp_fifo.sv
// Module: transmit byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scp_fifo
	import scp_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = SCP_FIFO_DEPTH
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage words
	logic [AW-1:0]    wr_ptr_reg;      // Next write slot
	logic [AW-1:0]    wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg;      // Next read slot
	logic [AW-1:0]    rd_ptr_next;
	logic [CW-1:0]    count_reg;       // Words held
	logic [CW-1:0]    count_next;
	logic             push;
	logic             pop;

	// Honest flags straight from the count
	assign in_ready  = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// ------------------------------------------------------------------
	// Pointer and count update
	// ------------------------------------------------------------------
	always_comb
	begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next  = count_reg;
		if (push)
			wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
		if (pop)
			rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// Storage carries no reset; it is only read behind out_valid
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end
endmodule
`default_nettype wire

// ===== verilog/scp_port.sv
// Module: serial port clock divider, data buffers and transfer sequencer
//
// Contract
// - Master clock is system clock over 2(N+1)
// - Data write buffers byte, starts master transfer
// - Data read returns the receive buffer
// - Clock polarity one inverts idle level, edges
// - Slave output valid within four cycles
// - Slave output released within four cycles
// - Phase one: output changes six to eight
// - Select mode picks three-wire, input, driven
// - Empty flag set when last byte enters shifter; the phase-one SCP_HOLD load leaves it in the buffer, so the flag stays clear
`timescale 1ns/1ps
`default_nettype none
module scp_port
	import scp_pkg::*;
#(
	parameter int FIFO_DEPTH = SCP_FIFO_DEPTH
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic [7:0]      sfr_rdata,
	output logic            sfr_wr_ready,
	// Configuration levels
	input  wire logic       spi_enable,
	input  wire logic       master_mode,
	input  wire logic       clock_polarity_select,
	input  wire logic       clock_phase_select,
	input  wire logic [1:0] slave_select_mode,
	// Status
	output logic            tx_buffer_empty_flag,
	// Serial clock pin
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	// Master-out pin
	input  wire logic       mosi_in,
	output logic            mosi_out,
	output logic            mosi_oe,
	// Master-in pin
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe,
	// Slave select pin
	input  wire logic       slave_select_n_in,
	output logic            slave_select_n_out,
	output logic            slave_select_n_oe
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	scp_state_t state_reg;          // Sequencer state
	scp_state_t state_next;
	logic [7:0] clk_div_reg;        // Clock-rate divider register
	logic [7:0] clk_div_next;
	logic [7:0] rx_buf_reg;         // Receive buffer
	logic [7:0] rx_buf_next;
	logic [7:0] rdata_reg;          // Read answer
	logic [7:0] rdata_next;
	logic [7:0] tx_shift_reg;       // Outgoing bits, MSB on the pin
	logic [7:0] tx_shift_next;
	logic [7:0] rx_shift_reg;       // Incoming bits
	logic [7:0] rx_shift_next;
	logic       tx_loaded_reg;      // Shifter holds a fresh byte
	logic       tx_loaded_next;
	logic [7:0] div_cnt_reg;        // Half-period counter
	logic [7:0] div_cnt_next;
	logic [3:0] edge_cnt_reg;       // Master clock edge index
	logic [3:0] edge_cnt_next;
	logic [2:0] bit_cnt_reg;        // Slave sample count
	logic [2:0] bit_cnt_next;
	logic [2:0] hold_cnt_reg;       // Delay after last slave edge
	logic [2:0] hold_cnt_next;
	logic       sck_lvl_reg;        // Master clock, polarity zero sense
	logic       sck_lvl_next;
	logic       miso_oe_reg;        // Slave drives its output
	logic       miso_oe_next;
	logic [3:0] sync1_reg;          // First synchroniser stage
	logic [3:0] sync2_reg;          // Second stage, safe to read
	logic       sck_prev_reg;       // Previous synced clock for edges
	logic       fifo_valid;
	logic [7:0] fifo_data;
	logic       fifo_pop;
	logic       wr_data;
	logic       selected;
	logic       toggle;
	logic       lead_e;
	logic       trail_e;
	logic       s_sample;
	logic       s_shift;

	wire logic sck_s  = sync2_reg[0];
	wire logic mosi_s = sync2_reg[1];
	wire logic miso_s = sync2_reg[2];
	wire logic nss_s  = sync2_reg[3];

	// Decode of a register address, used by writes and reads
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	// Pins are foreign to clk; only stage two is ever read
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			// Idle levels for polarity zero: no false clock edge
			// follows reset; select starts high
			sync1_reg    <= 4'h8;
			sync2_reg    <= 4'h8;
			sck_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg    <= {slave_select_n_in, miso_in, mosi_in, sck_in};
			sync2_reg    <= sync1_reg;
			sck_prev_reg <= sync2_reg[0];
		end
	end

	// ------------------------------------------------------------------
	// Transmit buffer
	// ------------------------------------------------------------------
	assign wr_data = sfr_wr & hit(sfr_addr, SCP_ADDR_DATA);
	// Empty as soon as the idle pop moves the last byte into the shifter
	assign tx_buffer_empty_flag = ~fifo_valid;
	// Shifter refills only between transfers
	assign fifo_pop = (state_reg == SCP_IDLE) & ~tx_loaded_reg;

	scp_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (wr_data),
		.in_ready  (sfr_wr_ready),
		.in_data   (sfr_wdata),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// ------------------------------------------------------------------
	// Slave select and edge decode
	// ------------------------------------------------------------------
	// Three-wire slave is always selected; four-wire follows the pin
	always_comb
	begin
		case (slave_select_mode)
			SCP_SSM_3WIRE: selected = 1'b1;
			SCP_SSM_4WIRE: selected = ~nss_s;
			default:       selected = 1'b0;
		endcase
	end

	// Edges seen in polarity-zero sense
	assign lead_e  = (sck_s ^ clock_polarity_select) &
		~(sck_prev_reg ^ clock_polarity_select);
	assign trail_e = ~(sck_s ^ clock_polarity_select) &
		(sck_prev_reg ^ clock_polarity_select);
	// Phase zero samples on leading edges, phase one on trailing
	assign s_sample = clock_phase_select ? trail_e : lead_e;
	assign s_shift  = clock_phase_select ? lead_e : trail_e;
	assign toggle   = (div_cnt_reg == clk_div_reg);

	// ------------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------------
	always_comb
	begin
		state_next     = state_reg;
		tx_shift_next  = tx_shift_reg;
		rx_shift_next  = rx_shift_reg;
		rx_buf_next    = rx_buf_reg;
		tx_loaded_next = tx_loaded_reg;
		div_cnt_next   = div_cnt_reg;
		edge_cnt_next  = edge_cnt_reg;
		bit_cnt_next   = bit_cnt_reg;
		hold_cnt_next  = hold_cnt_reg;
		sck_lvl_next   = 1'b0;
		case (state_reg)
			SCP_IDLE:
			begin
				div_cnt_next  = 8'h00;
				edge_cnt_next = 4'h0;
				bit_cnt_next  = 3'h0;
				if (fifo_pop && fifo_valid)
				begin
					// Byte moves from buffer into shifter
					tx_shift_next  = fifo_data;
					tx_loaded_next = 1'b1;
				end
				else if (spi_enable && master_mode && tx_loaded_reg)
					state_next = SCP_MASTER;
				else if (spi_enable && !master_mode && selected)
					state_next = SCP_SLAVE;
			end
			SCP_MASTER:
			begin
				sck_lvl_next = sck_lvl_reg;
				div_cnt_next = toggle ? 8'h00 : div_cnt_reg + 8'h01;
				if (toggle)
				begin
					sck_lvl_next  = ~sck_lvl_reg;
					edge_cnt_next = edge_cnt_reg + 4'h1;
					// Even edges lead, odd edges trail
					if (edge_cnt_reg[0] == clock_phase_select)
						rx_shift_next = {rx_shift_reg[6:0], miso_s};
					else if (edge_cnt_reg != 4'h0)
						tx_shift_next = {tx_shift_reg[6:0], 1'b0};
					if (edge_cnt_reg == SCP_LAST_EDGE)
					begin
						rx_buf_next    = rx_shift_next;
						tx_loaded_next = 1'b0;
						sck_lvl_next   = 1'b0;
						state_next     = SCP_IDLE;
					end
				end
				if (!spi_enable)
					state_next = SCP_IDLE;
			end
			SCP_SLAVE:
			begin
				if (s_sample)
				begin
					rx_shift_next = {rx_shift_reg[6:0], mosi_s};
					bit_cnt_next  = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == SCP_LAST_BIT)
					begin
						rx_buf_next    = rx_shift_next;
						tx_loaded_next = 1'b0;
						hold_cnt_next  = 3'h0;
						// Phase one keeps the last bit, then moves on late
						state_next = clock_phase_select ? SCP_HOLD : SCP_IDLE;
					end
				end
				else if (s_shift && !(clock_phase_select && bit_cnt_reg == 3'h0))
					tx_shift_next = {tx_shift_reg[6:0], 1'b0};
				// Deselect or a switch to master abandons the byte;
				// three-wire select never drops, so mode must free us
				if (!selected || !spi_enable || master_mode)
					state_next = SCP_IDLE;
			end
			SCP_HOLD:
			begin
				hold_cnt_next = hold_cnt_reg + 3'h1;
				if (hold_cnt_reg == SCP_HOLD_CYC - 3'h1)
				begin
					// Output changes six to eight cycles after the edge
					tx_shift_next  = fifo_valid ? fifo_data : SCP_DATA_RST;
					tx_loaded_next = fifo_valid;
					state_next     = SCP_IDLE;
				end
			end
			default: state_next = SCP_IDLE;
		endcase
		// Output enable follows the synced select within four cycles
		miso_oe_next = spi_enable & ~master_mode & selected;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg     <= SCP_IDLE;
			tx_shift_reg  <= SCP_DATA_RST;
			rx_shift_reg  <= SCP_DATA_RST;
			rx_buf_reg    <= SCP_DATA_RST;
			tx_loaded_reg <= 1'b0;
			div_cnt_reg   <= 8'h00;
			edge_cnt_reg  <= 4'h0;
			bit_cnt_reg   <= 3'h0;
			hold_cnt_reg  <= 3'h0;
			sck_lvl_reg   <= 1'b0;
			miso_oe_reg   <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			tx_shift_reg  <= tx_shift_next;
			rx_shift_reg  <= rx_shift_next;
			rx_buf_reg    <= rx_buf_next;
			tx_loaded_reg <= tx_loaded_next;
			div_cnt_reg   <= div_cnt_next;
			edge_cnt_reg  <= edge_cnt_next;
			bit_cnt_reg   <= bit_cnt_next;
			hold_cnt_reg  <= hold_cnt_next;
			sck_lvl_reg   <= sck_lvl_next;
			miso_oe_reg   <= miso_oe_next;
		end
	end

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	// Writes land at once; reads answer one cycle later
	always_comb
	begin
		clk_div_next = clk_div_reg;
		rdata_next   = rdata_reg;
		if (sfr_wr && hit(sfr_addr, SCP_ADDR_CLK_DIV))
			clk_div_next = sfr_wdata;
		if (sfr_rd)
		begin
			if (hit(sfr_addr, SCP_ADDR_CLK_DIV))
				rdata_next = clk_div_reg;
			else if (hit(sfr_addr, SCP_ADDR_DATA))
				rdata_next = rx_buf_reg;
			else
				rdata_next = SCP_UNMAPPED;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			clk_div_reg <= SCP_CLK_DIV_RST;
			rdata_reg   <= SCP_DATA_RST;
		end
		else
		begin
			clk_div_reg <= clk_div_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	assign sfr_rdata = rdata_reg;
	assign sck_out   = sck_lvl_reg ^ clock_polarity_select;
	assign sck_oe    = spi_enable & master_mode;
	assign mosi_out  = tx_shift_reg[7];
	assign mosi_oe   = spi_enable & master_mode;
	assign miso_out  = tx_shift_reg[7];
	assign miso_oe   = miso_oe_reg;
	// Driven mode copies the low mode bit onto the pin
	assign slave_select_n_out = slave_select_mode[0];
	assign slave_select_n_oe  = slave_select_mode[SCP_SSM_DRIVE] &
		spi_enable;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [8:0] gap_cnt_reg; // Cycles since the last master clock change
	always_ff @(posedge clk)
	begin
		if (!rst_n || state_reg != SCP_MASTER || sck_lvl_next != sck_lvl_reg)
			gap_cnt_reg <= 9'h000;
		else
			gap_cnt_reg <= gap_cnt_reg + 9'h001;
	end

	a_div_half_period: assert property (
		state_reg == SCP_MASTER && $changed(sck_lvl_reg) && edge_cnt_reg != 4'h1
		|-> $past(gap_cnt_reg) == {1'b0, clk_div_reg})
		else $error("master clock half period wrong");
	a_write_starts: assert property (
		wr_data && sfr_wr_ready && state_reg == SCP_IDLE && !tx_loaded_reg
		&& !fifo_valid && spi_enable && master_mode
		|-> ##3 state_reg == SCP_MASTER)
		else $error("data write did not start master transfer");
	a_read_rx: assert property (
		sfr_rd && hit(sfr_addr, SCP_ADDR_DATA) |=> sfr_rdata == $past(rx_buf_reg))
		else $error("data read not from receive buffer");
	a_sck_idle: assert property (
		state_reg == SCP_IDLE && sck_oe |-> sck_out == clock_polarity_select)
		else $error("idle clock level wrong");
	a_miso_valid: assert property (
		spi_enable && !master_mode && slave_select_mode == SCP_SSM_4WIRE
		&& $fell(slave_select_n_in) ##1 !slave_select_n_in [*3]
		|-> miso_oe)
		else $error("slave output late after select");
	a_miso_release: assert property (
		slave_select_mode == SCP_SSM_4WIRE && $rose(slave_select_n_in)
		##1 slave_select_n_in [*3] |-> !miso_oe)
		else $error("slave output not released");
	a_hold_len: assert property (
		$rose(state_reg == SCP_HOLD) |-> (state_reg == SCP_HOLD) [*4]
		##1 state_reg == SCP_IDLE)
		else $error("late output change timing wrong");
	a_select_drive: assert property (
		slave_select_mode[1] && spi_enable
		|-> slave_select_n_oe && slave_select_n_out == slave_select_mode[0])
		else $error("driven select pin wrong");
	a_eight_bits: assert property (
		state_reg == SCP_MASTER && toggle && edge_cnt_reg == SCP_LAST_EDGE
		|=> state_reg == SCP_IDLE && rx_buf_reg == $past(rx_shift_next))
		else $error("master transfer not eight bits");

	c_master_done: cover property (
		state_reg == SCP_MASTER ##1 state_reg == SCP_IDLE);
	c_slave_done: cover property (
		state_reg == SCP_SLAVE ##1 state_reg == SCP_IDLE);
	c_hold_seen: cover property (state_reg == SCP_HOLD);
	c_fifo_full: cover property (!sfr_wr_ready);
endmodule
`default_nettype wire

// ===== sim/scp_peer.sv
// Partner model: far-side serial device, slave responder or framing master
`timescale 1ns/1ps
`default_nettype none
module scp_peer (
	// Clock
	input  wire logic clk,
	// Resolved pin levels
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic miso,
	// Drives toward the port
	output logic      p_sck,
	output logic      p_mosi,
	output logic      p_miso,
	output logic      p_ss_n
);
	logic [7:0] tx = 8'h00; // Byte sent in slave role
	logic [7:0] rx = 8'h00; // Byte seen on the far line

	// Idle: clock still low, select high
	initial
	begin
		p_sck = 1'b0;
		p_mosi = 1'b0;
		p_ss_n = 1'b1;
	end

	// Slave role shows its MSB first
	assign p_miso = tx[7];

	// Sample on the leading edge, polarity and phase zero
	always @(posedge sck)
		rx <= {rx[6:0], p_ss_n ? mosi : miso};

	// Slave role shifts on the trailing edge; fill bit keeps line moving
	always @(negedge sck)
		if (p_ss_n)
			tx <= {tx[6:0], ~tx[0]};

	// Byte to answer with in slave role
	task automatic load(input logic [7:0] d);
		tx = d;
	endtask

	// Master role: one framed byte, clock high six cycles, low seven
	task automatic frame(input logic [7:0] d);
		int i;
		@(posedge clk);
		#1 p_ss_n = 1'b0;
		repeat (3) @(posedge clk);
		for (i = 7; i >= 0; i--)
		begin
			@(posedge clk);
			#1 p_mosi = d[i];
			repeat (6) @(posedge clk);
			#1 p_sck = 1'b1;
			repeat (6) @(posedge clk);
			#1 p_sck = 1'b0;
		end
		repeat (3) @(posedge clk);
		#1 p_ss_n = 1'b1;
		// Released line must not look like held data
		p_mosi = ~d[0];
	endtask
endmodule
`default_nettype wire

// ===== sim/scp_port_test.sv
// Testbench: registers, master and slave bytes, buffer of the serial port
`timescale 1ns/1ps
`default_nettype none
module scp_port_test;
	import scp_pkg::*;
	logic       clk, rst_n, en, mm, pol, pha, wr, rd;
	logic [1:0] ssm;
	logic [7:0] addr, wdata, rdata;
	logic       rdy, empty, sck_o, sck_e, mosi_o, mosi_e;
	logic       miso_o, miso_e, ss_o, ss_e, p_sck, p_mosi, p_miso, p_ss;
	wire        sck, mosi, miso, ss_n; // Resolved pin levels
	int         n_errors, checks, cyc, edges, gap, t_last, i, m;
	logic       sck_q;

	// Wires follow whoever enables its driver
	assign sck = sck_e ? sck_o : p_sck;
	assign mosi = mosi_e ? mosi_o : p_mosi;
	assign miso = miso_e ? miso_o : p_miso;
	assign ss_n = ss_e ? ss_o : p_ss;

	scp_port i_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(addr),
		.sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.sfr_wr_ready(rdy), .spi_enable(en), .master_mode(mm),
		.clock_polarity_select(pol), .clock_phase_select(pha),
		.slave_select_mode(ssm), .tx_buffer_empty_flag(empty),
		.sck_in(sck), .sck_out(sck_o), .sck_oe(sck_e),
		.mosi_in(mosi), .mosi_out(mosi_o), .mosi_oe(mosi_e),
		.miso_in(miso), .miso_out(miso_o), .miso_oe(miso_e),
		.slave_select_n_in(ss_n), .slave_select_n_out(ss_o),
		.slave_select_n_oe(ss_e));

	scp_peer peer (.clk(clk), .sck(sck), .mosi(mosi), .miso(miso),
		.p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss));

	// 125 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Cycle count and clock edge spacing seen on the pin
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		sck_q <= sck_o;
		if (sck_o !== sck_q)
		begin
			edges <= edges + 1;
			gap <= cyc - t_last;
			t_last <= cyc;
		end
	end

	// Hang guard, well above the longest run
	always @(posedge clk)
		if (cyc == 12000)
		begin
			n_errors++;
			close_out();
		end

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// One write, strobe up for exactly one edge
	task automatic put(input logic [7:0] a, d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask

	// One read; answer is registered at the strobe edge
	task automatic get(input logic [7:0] a, exp, input string nm);
		@(posedge clk);
		#1 addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1 rd = 1'b0;
		chk(nm, {8'h00, rdata}, {8'h00, exp});
	endtask

	// Master byte: divider, flag, edge spacing, both directions;
	// ld is what the peer holds, back what the port should receive
	task automatic mxfer(input logic [7:0] div, d, ld, back);
		put(SCP_ADDR_CLK_DIV, div);
		get(SCP_ADDR_CLK_DIV, div, "divider");
		peer.load(ld);
		edges = 0;
		put(SCP_ADDR_DATA, d);
		chk("flag pushed", 16'(empty), 16'h0000);
		@(posedge clk);
		#1 chk("flag popped", 16'(empty), 16'h0001);
		for (i = 0; i < 5000 && edges < 16; i++)
			@(posedge clk);
		chk("edges", 16'(edges), 16'h0010);
		chk("half period", 16'(gap), {8'h00, div} + 16'h0001);
		get(SCP_ADDR_DATA, back, "rx buffer");
		chk("peer rx", {8'h00, peer.rx}, {8'h00, d});
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{n_errors, checks, cyc, edges, gap, t_last} = '0;
		{rst_n, wr, rd, addr, wdata, sck_q} = '0;
		{en, mm, pol, pha, ssm} = {4'hC, 2'h0};
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		get(SCP_ADDR_CLK_DIV, SCP_CLK_DIV_RST, "divider reset");
		get(SCP_ADDR_DATA, SCP_DATA_RST, "data reset");
		get(8'h00, SCP_UNMAPPED, "unmapped");
		chk("reset flag", 16'(empty), 16'h0001);
		$display("test reset done");
		pol = 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("idle clock", 16'(sck_o), 16'h0001);
		pol = 1'b0;
		mxfer(8'h03, 8'hA5, 8'h3C, 8'h3C);
		mxfer(8'hFF, 8'h69, 8'hC3, 8'hC3);
		// Polarity and phase one; the peer shifts on the first leading
		// edge too, so it is loaded one bit ahead of what should arrive
		pol = 1'b1;
		pha = 1'b1;
		mxfer(8'h03, 8'h96, 8'h2D, 8'h5A);
		pol = 1'b0;
		pha = 1'b0;
		$display("test master done");
		mm = 1'b0;
		ssm = SCP_SSM_4WIRE;
		put(SCP_ADDR_DATA, 8'hA5);
		repeat (3) @(posedge clk);
		fork
			peer.frame(8'h3C);
			begin
				repeat (5) @(posedge clk);
				#1 chk("miso drive", 16'(miso_e), 16'h0001);
				chk("miso msb", 16'(miso_o), 16'h0001);
			end
		join
		repeat (4) @(posedge clk);
		#1 chk("miso release", 16'(miso_e), 16'h0000);
		get(SCP_ADDR_DATA, 8'h3C, "slave rx");
		chk("slave tx", {8'h00, peer.rx}, 16'h00A5);
		// Phase one: output moves six to eight cycles after last edge
		pha = 1'b1;
		put(SCP_ADDR_DATA, 8'hA5);
		peer.frame(8'h96);
		repeat (2) @(posedge clk);
		#1 chk("late hold", 16'(miso_o), 16'h0001);
		repeat (3) @(posedge clk);
		#1 chk("late change", 16'(miso_o), 16'h0000);
		get(SCP_ADDR_DATA, 8'h96, "phase one rx");
		pha = 1'b0;
		$display("test slave done");
		for (m = 0; m < 4; m++)
		begin
			ssm = 2'(m);
			repeat (2) @(posedge clk);
			#1 chk("select drive", 16'(ss_e), 16'(m[1]));
			if (m[1])
				chk("select level", 16'(ss_o), 16'(m[0]));
		end
		$display("test select done");
		ssm = SCP_SSM_3WIRE;
		for (m = 0; m < 40; m++)
			put(SCP_ADDR_DATA, 8'(m));
		chk("buffer full", 16'(rdy), 16'h0000);
		put(SCP_ADDR_CLK_DIV, 8'h00);
		mm = 1'b1;
		for (i = 0; i < 4000 && empty !== 1'b1; i++)
			@(posedge clk);
		repeat (60) @(posedge clk);
		#1 chk("drained", 16'(empty), 16'h0001);
		chk("space", 16'(rdy), 16'h0001);
		$display("test buffer done");
		close_out();
	end
endmodule
`default_nettype wire
